// file: pkg/psie_consts.svh
// Constants for the port status, service data and event instruction interpreter
`ifndef PSIE_CONSTS_SVH
`define PSIE_CONSTS_SVH
// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define PSIE_ADDR_CMD      8'h00
`define PSIE_ADDR_LEN      8'h01
`define PSIE_ADDR_STAT     8'h02
`define PSIE_BUF_SEL_BIT   7
// ----------------------------------------------------------------
// Field positions of the command and status registers
// ----------------------------------------------------------------
`define PSIE_CMD_ACC_LSB   0
`define PSIE_CMD_ATTR_LSB  8
`define PSIE_CMD_DEV_LSB   16
`define PSIE_CMD_RD_BIT    24
`define PSIE_CMD_GO_BIT    31
`define PSIE_STAT_CODE_LSB 16
// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define PSIE_ATTR          8'h05
`define PSIE_ACC_STATUS    8'h0d
`define PSIE_ACC_ISDU      8'h10
`define PSIE_ACC_EVENT     8'h20
`define PSIE_DEV_ALL       8'h00
`define PSIE_DEV_FIRST     8'h01
`define PSIE_DEV_LAST      8'h08
// ----------------------------------------------------------------
// Line modes, service data control values, completion codes
// ----------------------------------------------------------------
`define PSIE_CQ_LINK       4'h1
`define PSIE_CTL_EVEN      8'h00
`define PSIE_CTL_ODD       8'h80
`define PSIE_CTL_ARM       8'h01
`define PSIE_CTL_NORMAL    8'h00
`define PSIE_CTL_BUSY      8'h01
`define PSIE_CMP_OK        16'h0000
`define PSIE_CMP_NOT_LINK  16'h8202
`define PSIE_CMP_BAD_PARAM 16'h0001
// ----------------------------------------------------------------
// Transfer lengths in words
// ----------------------------------------------------------------
`define PSIE_ISDU_MIN      7'd2
`define PSIE_ISDU_MAX      7'd118
`define PSIE_EVT_MIN       7'd2
`define PSIE_EVT_MAX       7'd12
`define PSIE_STAT_ONE      7'd5
`define PSIE_STAT_ALL      7'd40
`define PSIE_STAT_WORDS    3'd5
`endif

// file: pkg/psie_pkg.sv
// Types shared by the instruction interpreter and its environment
package psie_pkg;
  // ----------------------------------------------------------------
  // Per-port live status delivered by the port logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  aux_input_line_mode;
    logic [3:0]  cq_mode;
    logic [7:0]  cycle_time;
    logic [7:0]  baud_rate_code;
    logic [7:0]  conn_state;
    logic [15:0] vendor_id;
    logic [23:0] device_id;
  } psie_port_stat_t;

  // ----------------------------------------------------------------
  // Field-side operation request
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSIE_OP_WRITE,
    PSIE_OP_READ,
    PSIE_OP_EVENT
  } psie_op_t;

  typedef struct packed {
    psie_op_t    op;
    logic [2:0]  port;
    logic [15:0] index;
    logic [7:0]  subidx;
    logic [6:0]  len;
  } psie_fd_req_t;

  typedef struct packed {
    logic        done;
    logic        busy;
    logic [6:0]  len;
  } psie_fd_rsp_t;

  typedef struct packed {
    logic        en;
    logic [6:0]  addr;
    logic [15:0] data;
  } psie_fd_wr_t;
endpackage : psie_pkg

// file: verification/psie_cmd_bench.sv
// Self-checking bench for the instruction interpreter
`timescale 1ns/1ps
`include "psie_consts.svh"
module psie_cmd_bench
  import psie_pkg::*;
;
  logic                  clk, arst_n, read, write, slow, waitrequest, busy;
  logic                  fd_req_valid, fd_req_ready;
  logic [7:0]            address;
  logic [31:0]           writedata, readdata, q;
  logic [15:0]           frd;
  psie_port_stat_t [7:0] port_stat;
  psie_fd_req_t          fd_req, last_req;
  psie_fd_wr_t           fd_wr;
  psie_fd_rsp_t          fd_rsp;
  logic [3:0]            cqm [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'h4, 4'h0, 4'h1};
  logic [7:0]            cst [4] = '{8'h00, 8'h40, 8'h80, 8'hff};
  int                    failures, checks, nreq, n0, n;
  psie_cmd u_dut (.clk, .arst_n, .ce(1'b1), .address, .read, .write, .writedata,
    .byteenable(4'hf), .readdata, .waitrequest, .port_stat, .fd_req_valid, .fd_req,
    .fd_req_ready, .fd_rd_addr(7'h00), .fd_rd_data(frd), .fd_wr, .fd_rsp, .busy);
  psie_field_model u_fd (.clk, .arst_n, .slow, .fd_req_valid, .fd_req, .fd_req_ready,
    .fd_wr, .fd_rsp);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (fd_req_valid === 1'b1 && fd_req_ready === 1'b1) begin
      nreq     <= nreq + 1;
      last_req <= fd_req;
    end
  end
  // ----
  // Tasks
  // ----
  task automatic final_report;
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic stop;
    failures++;
    $display("ERROR %0t wait timed out", $time);
    final_report();
  endtask : stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Holds the request until waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= !w;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 40);
    if (waitrequest !== 1'b0) stop();
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic run(input logic [7:0] acc, input logic [7:0] dv, input logic r,
                     input logic [6:0] len);
    int i;
    bus(1'b1, `PSIE_ADDR_LEN, {25'h0, len});
    bus(1'b1, `PSIE_ADDR_CMD, {1'b1, 6'h00, r, dv, `PSIE_ATTR, acc});
    for (i = 0; i < 200; i++) begin
      bus(1'b0, `PSIE_ADDR_STAT, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (i == 200) stop();
  endtask : run
  task automatic wb(input int k, input logic [15:0] d);
    bus(1'b1, 8'h80 + 8'(k), {16'h0, d});
  endtask : wb
  task automatic cb(input int k, input logic [15:0] e);
    bus(1'b0, 8'h80 + 8'(k), 32'h0);
    chk(q, {16'h0, e});
  endtask : cb
  function automatic logic [15:0] ew(input int p, input int k);
    psie_port_stat_t s;
    s = port_stat[p];
    case (k)
      0: ew = {s.aux_input_line_mode, s.cq_mode, 8'(p + 1)};
      1: ew = {s.baud_rate_code, s.cycle_time};
      2: ew = {s.vendor_id[15:8], s.conn_state};
      3: ew = {s.device_id[23:16], s.vendor_id[7:0]};
      default: ew = {s.device_id[7:0], s.device_id[15:8]};
    endcase
    if (k > 0 && s.cq_mode != `PSIE_CQ_LINK) ew = 16'h0000;
  endfunction : ew
  // ----
  // Sequence
  // ----
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {read, write, slow, address, writedata} = '0;
    {failures, checks, nreq} = '0;
    for (int p = 0; p < 8; p++) port_stat[p] = '{4'(p % 2), cqm[p], 8'h0a + 8'(p),
      8'(p % 3), cst[p % 4], 16'h1100 + 16'(p), 24'hab0c00 + 24'(p)};
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    run(`PSIE_ACC_STATUS, 8'h00, 1'b1, 7'd0);
    for (int i = 0; i < 40; i++) cb(i, ew(i / 5, i % 5));
    run(`PSIE_ACC_STATUS, 8'h06, 1'b1, 7'd0);
    for (int i = 0; i < 5; i++) cb(i, ew(5, i));
    wb(0, 16'h0102);
    wb(1, 16'h0107);
    run(`PSIE_ACC_ISDU, 8'h05, 1'b0, 7'd2);
    chk(q >> 16, 32'h8202);
    run(`PSIE_ACC_ISDU, 8'h07, 1'b1, 7'd4);
    chk(q >> 16, 32'h8202);
    n0 = nreq;
    wb(1, 16'h0107);
    run(`PSIE_ACC_ISDU, 8'h03, 1'b0, 7'd2);
    chk(q & 32'hffff0002, 32'h2);
    chk(32'(nreq), 32'(n0));
    slow <= 1'b1;
    run(`PSIE_ACC_ISDU, 8'h03, 1'b1, 7'd4);
    chk(q & 32'h2, 32'h2);
    chk(32'({last_req.op, last_req.port, last_req.index, last_req.subidx}),
        32'({PSIE_OP_READ, 3'h2, 16'h0102, 8'h07}));
    cb(1, 16'h0107);
    slow <= 1'b0;
    run(`PSIE_ACC_ISDU, 8'h03, 1'b1, 7'd4);
    chk(q & 32'hffff0002, 32'h0);
    cb(0, 16'h0102);
    chk({16'h0, frd}, 32'h0102);
    cb(1, 16'h0007);
    cb(2, 16'h1233);
    wb(1, 16'h01ff);
    run(`PSIE_ACC_ISDU, 8'h03, 1'b0, 7'd2);
    run(`PSIE_ACC_STATUS, 8'h01, 1'b1, 7'd0);
    run(`PSIE_ACC_ISDU, 8'h03, 1'b1, 7'd4);
    chk(q >> 16, 32'h1);
    for (int c = 0; c < 2; c++) begin
      wb(1, {c ? 8'h80 : 8'h00, 8'h05});
      run(`PSIE_ACC_ISDU, 8'h03, 1'b0, c ? 7'd3 : 7'd118);
      chk(32'({last_req.op, last_req.len}), 32'({PSIE_OP_WRITE, c ? 7'd3 : 7'd118}));
    end
    for (int c = 0; c < 2; c++) begin
      n = c ? 12 : 2;
      run(`PSIE_ACC_EVENT, 8'h03, 1'b1, 7'(n));
      chk(q >> 16, 32'h0);
      cb(0, 16'h1233);
      cb(1, 16'h3212);
      for (int k = 2; k < n; k++) cb(k, 16'h0000);
    end
    final_report();
  end
endmodule : psie_cmd_bench

// file: verification/psie_cmd_monitor.sv
// Port checks for the instruction interpreter
`timescale 1ns/1ps
`include "psie_consts.svh"
module psie_cmd_monitor
  import psie_pkg::*;
#(
  parameter int NPORT = 8
) (
  input wire logic                        clk,
  input wire logic                        arst_n,
  input wire logic [7:0]                  address,
  input wire logic                        write,
  input wire logic [31:0]                 writedata,
  input wire psie_port_stat_t [NPORT-1:0] port_stat,
  input wire logic                        fd_req_valid,
  input wire psie_fd_req_t                fd_req,
  input wire logic                        fd_req_ready,
  input wire logic                        busy
);
  // ----
  // Start decode
  // ----
  logic [6:0] len_reg;
  logic [7:0] ctl_reg;
  wire  [7:0] acc  = writedata[7:0];
  wire  [7:0] dev  = writedata[23:16];
  wire        rd   = writedata[24];
  wire        go   = write && address == `PSIE_ADDR_CMD && writedata[31] && !busy
                     && writedata[15:8] == `PSIE_ATTR;
  wire        dok  = dev >= `PSIE_DEV_FIRST && dev <= `PSIE_DEV_LAST;
  wire        link = port_stat[dev[2:0] - 3'd1].cq_mode == `PSIE_CQ_LINK;
  wire        isdu = go && dok && acc == `PSIE_ACC_ISDU && len_reg >= `PSIE_ISDU_MIN
                     && len_reg <= `PSIE_ISDU_MAX;
  wire        evt  = go && dok && rd && link && acc == `PSIE_ACC_EVENT && !len_reg[0]
                     && len_reg >= `PSIE_EVT_MIN && len_reg <= `PSIE_EVT_MAX;
  wire        stat = go && rd && acc == `PSIE_ACC_STATUS;
  // Writes while busy are dropped, so the shadows use the same gate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      len_reg <= 7'h00;
      ctl_reg <= 8'h00;
    end else if (write && !busy) begin
      if (address == `PSIE_ADDR_LEN) len_reg <= writedata[6:0];
      if (address == 8'h81) ctl_reg <= writedata[15:8];
    end
  end
  // ----
  // Assertions
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_one_port; stat && dev != 8'h00; endsequence
  sequence s_done_soon; ##[1:12] !busy; endsequence
  sequence s_quiet; !fd_req_valid [*4]; endsequence
  AST_ONE_OP: assert property (fd_req_valid |-> busy)
    else $error("request while idle");
  AST_REQ_HOLD: assert property (fd_req_valid && !fd_req_ready |=> fd_req_valid
    && $stable(fd_req)) else $error("request not held");
  AST_EVT_GO: assert property (evt |=> busy)
    else $error("event not started");
  AST_NOT_LINK: assert property (isdu && !link |=> s_quiet)
    else $error("non-link request sent");
  AST_ARM_ONLY: assert property (isdu && link && !rd && ctl_reg == `PSIE_CTL_ARM |=> s_quiet)
    else $error("arming write sent");
  AST_STAT_ONE: assert property (s_one_port |-> !fd_req_valid throughout s_done_soon)
    else $error("status too long");
  AST_STAT_ALL: assert property (stat && dev == 8'h00 |=> busy [*8])
    else $error("status too short");
  AST_REQ_LEN: assert property (fd_req_valid && fd_req.op != PSIE_OP_EVENT |->
    fd_req.len >= `PSIE_ISDU_MIN && fd_req.len <= `PSIE_ISDU_MAX) else $error("bad length");
  AST_EVT_LEN: assert property (fd_req_valid && fd_req.op == PSIE_OP_EVENT |-> !fd_req.len[0]
    && fd_req.len >= `PSIE_EVT_MIN && fd_req.len <= `PSIE_EVT_MAX) else $error("bad event length");
endmodule : psie_cmd_monitor

bind psie_cmd psie_cmd_monitor #(.NPORT(NPORT)) u_mon (.clk, .arst_n, .address, .write,
  .writedata, .port_stat, .fd_req_valid, .fd_req, .fd_req_ready, .busy);

// file: verification/psie_field_model.sv
// Field-side responder for the instruction interpreter
`timescale 1ns/1ps
module psie_field_model
  import psie_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         slow,
  input  wire logic         fd_req_valid,
  input  wire psie_fd_req_t fd_req,
  output logic              fd_req_ready,
  output psie_fd_wr_t       fd_wr,
  output psie_fd_rsp_t      fd_rsp
);
  // ----
  // Answer sequencer
  // ----
  logic [3:0] cnt_reg;
  psie_op_t   op_reg;
  assign fd_req_ready = cnt_reg == 4'h0;
  assign fd_wr.en     = op_reg != PSIE_OP_WRITE && (cnt_reg == 4'h3 || cnt_reg == 4'h2);
  assign fd_wr.addr   = 7'(op_reg == PSIE_OP_EVENT ? 4'h3 - cnt_reg : 4'h5 - cnt_reg);
  // Data moves every cycle so a stale word cannot pass for a fresh one
  assign fd_wr.data   = {12'h123, cnt_reg};
  assign fd_rsp.done  = cnt_reg == 4'h1;
  assign fd_rsp.busy  = slow && op_reg == PSIE_OP_READ;
  assign fd_rsp.len   = op_reg == PSIE_OP_EVENT ? 7'd2 : 7'd4;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 4'h0;
      op_reg  <= PSIE_OP_WRITE;
    end else if (fd_req_valid && fd_req_ready) begin
      cnt_reg <= slow ? 4'h9 : 4'h4;
      op_reg  <= fd_req.op;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule : psie_field_model

// file: verilog/psie_cmd.sv
// Dedicated instruction interpreter: port status, service data and event reads
// ----------------------------------------------------------------
// Operation
// - Status words carry a port number 1 to 8.
// - Combined line mode: 0 off, 1 link, 3 switching in, 4 switching out.
// - Auxiliary input line mode: 0 off, 1 input operation.
// - Cycle time reported in 100 us steps.
// - Baud rate code 0, 1, 2 for the three link speeds.
// - Connection state 00, 40, 80 or ff.
// - Vendor and device identifiers placed most significant byte first.
// - Non-link port reports zero in cycle, baud, connection and identifiers.
// - Service data instruction is attribute 05, access 10, ports 1 to 8.
// - Service data length 2 to 118 words.
// - Word zero holds the 16-bit parameter index.
// - Word one low byte holds the sub-index 0 to 255.
// - Control 01 write only arms a pending read selection.
// - Read returns control 00 for valid data, 01 for busy.
// - Service data on a non-link port completes with 8202.
// - Any intervening operation discards the pending read selection.
// - Event read instruction is attribute 05, access 20, ports 1 to 8.
// - Event read is two words per event, 2 to 12 words.
// - Event codes little endian; empty slots read as zero.
// - Status report is 5 words per port, 40 for all ports.
// ----------------------------------------------------------------
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "psie_consts.svh"

module psie_cmd
  import psie_pkg::*;
#(
  parameter int NPORT    = 8,
  parameter int BUF_WORDS = 118
) (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        ce,
  input  wire logic [7:0]                  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  input  wire logic [3:0]                  byteenable,
  output logic      [31:0]                 readdata,
  output logic                             waitrequest,
  input  wire psie_port_stat_t [NPORT-1:0] port_stat,
  output logic                             fd_req_valid,
  output psie_fd_req_t                     fd_req,
  input  wire logic                        fd_req_ready,
  input  wire logic [6:0]                  fd_rd_addr,
  output logic      [15:0]                 fd_rd_data,
  input  wire psie_fd_wr_t                 fd_wr,
  input  wire psie_fd_rsp_t                fd_rsp,
  output logic                             busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSIE_IDLE,
    PSIE_FILL,
    PSIE_FD_REQ,
    PSIE_FD_WAIT,
    PSIE_ZERO,
    PSIE_HDR
  } psie_state_t;

  psie_state_t   state_reg;
  psie_state_t   state_next;
  logic [15:0]   buf_mem [BUF_WORDS];
  logic [31:0]   cmd_reg;
  logic [6:0]    len_reg;
  logic [15:0]   cmp_reg;
  logic [6:0]    cnt_reg;
  logic [6:0]    cnt_next;
  logic [6:0]    end_reg;
  logic [6:0]    end_next;
  logic [15:0]   cmp_next;
  logic          rd_done_reg;
  logic          pend_reg;
  logic          pend_next;
  logic [2:0]    pend_port_reg;
  logic [15:0]   pend_index_reg;
  logic [7:0]    pend_sub_reg;
  logic          busy_rsp_reg;
  logic          req_valid_next;
  psie_fd_req_t  req_next;

  // ----------------------------------------------------------------
  // Status word builder
  // ----------------------------------------------------------------
  function automatic logic [15:0] stat_word(input psie_port_stat_t s,
                                            input logic [3:0] num,
                                            input logic [2:0] k);
    logic        link;
    logic [15:0] w;
    link = (s.cq_mode == `PSIE_CQ_LINK);
    w    = 16'h0000;
    unique case (k)
      3'd0:    w = {s.aux_input_line_mode, s.cq_mode, 4'h0, num};
      3'd1:    w = {s.baud_rate_code, s.cycle_time};
      3'd2:    w = {s.vendor_id[15:8], s.conn_state};
      3'd3:    w = {s.device_id[23:16], s.vendor_id[7:0]};
      default: w = {s.device_id[7:0], s.device_id[15:8]};
    endcase
    if (!link && k != 3'd0) begin
      w = 16'h0000;
    end
    return w;
  endfunction : stat_word

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire         sel_buf   = address[`PSIE_BUF_SEL_BIT];
  wire  [6:0]  buf_idx   = address[6:0];
  wire         buf_ok    = sel_buf && (buf_idx < 7'(BUF_WORDS));
  wire         any_be    = |byteenable;
  wire         idle      = (state_reg == PSIE_IDLE);
  wire         wr_cmd    = write && any_be && !sel_buf && address == `PSIE_ADDR_CMD;
  wire         wr_len    = write && any_be && !sel_buf && address == `PSIE_ADDR_LEN;
  wire         go        = wr_cmd && writedata[`PSIE_CMD_GO_BIT] && idle;
  wire         sw_buf_wr = write && buf_ok && idle && (|byteenable[1:0]);

  assign waitrequest = read && !rd_done_reg;
  assign busy        = !idle;

  // ----------------------------------------------------------------
  // Command decode, taken from the fields written with the go bit
  // ----------------------------------------------------------------
  wire  [7:0]  c_acc   = writedata[`PSIE_CMD_ACC_LSB +: 8];
  wire  [7:0]  c_attr  = writedata[`PSIE_CMD_ATTR_LSB +: 8];
  wire  [7:0]  c_dev   = writedata[`PSIE_CMD_DEV_LSB +: 8];
  wire         c_rd    = writedata[`PSIE_CMD_RD_BIT];
  wire         c_one   = c_dev >= `PSIE_DEV_FIRST && c_dev <= `PSIE_DEV_LAST;
  wire  [2:0]  c_port  = 3'(c_dev - `PSIE_DEV_FIRST);
  wire         c_link  = port_stat[c_port].cq_mode == `PSIE_CQ_LINK;
  wire         is_stat = c_attr == `PSIE_ATTR && c_acc == `PSIE_ACC_STATUS && c_rd;
  wire         is_isdu = c_attr == `PSIE_ATTR && c_acc == `PSIE_ACC_ISDU;
  wire         is_evt  = c_attr == `PSIE_ATTR && c_acc == `PSIE_ACC_EVENT && c_rd;
  wire         len_isdu = len_reg >= `PSIE_ISDU_MIN && len_reg <= `PSIE_ISDU_MAX;
  wire         len_evt  = len_reg >= `PSIE_EVT_MIN && len_reg <= `PSIE_EVT_MAX
                          && !len_reg[0];
  wire  [7:0]  w1_ctl  = buf_mem[1][15:8];
  wire         ctl_arm = w1_ctl == `PSIE_CTL_ARM;
  wire         ctl_wr  = w1_ctl == `PSIE_CTL_EVEN || w1_ctl == `PSIE_CTL_ODD;
  wire         pend_hit = pend_reg && pend_port_reg == c_port;

  // ----------------------------------------------------------------
  // Buffer write source selection
  // ----------------------------------------------------------------
  wire         fill_we  = state_reg == PSIE_FILL;
  wire  [3:0]  fill_num = 4'(cnt_reg / 7'(`PSIE_STAT_WORDS)) + 4'(cmd_reg[`PSIE_CMD_DEV_LSB +: 4]);
  wire  [3:0]  fill_pnum = (cmd_reg[`PSIE_CMD_DEV_LSB +: 8] == `PSIE_DEV_ALL)
                           ? fill_num + 4'h1 : cmd_reg[`PSIE_CMD_DEV_LSB +: 4];
  wire  [2:0]  fill_k   = 3'(cnt_reg % 7'(`PSIE_STAT_WORDS));
  wire  [15:0] fill_w   = stat_word(port_stat[3'(fill_pnum - 4'h1)], fill_pnum, fill_k);
  wire         evt_op   = fd_req.op == PSIE_OP_EVENT;
  wire         fd_we    = state_reg == PSIE_FD_WAIT && fd_wr.en
                          && fd_wr.addr < 7'(BUF_WORDS);
  // Event codes land on odd words and are swapped into little endian order
  wire  [15:0] fd_w     = (evt_op && fd_wr.addr[0])
                          ? {fd_wr.data[7:0], fd_wr.data[15:8]} : fd_wr.data;
  wire  [15:0] hdr_w    = (cnt_reg == 7'd0) ? pend_index_reg
                          : {busy_rsp_reg ? `PSIE_CTL_BUSY : `PSIE_CTL_NORMAL,
                             pend_sub_reg};
  wire         zero_we  = state_reg == PSIE_ZERO;
  wire         hdr_we   = state_reg == PSIE_HDR;
  wire         mem_we   = sw_buf_wr || fill_we || fd_we || zero_we || hdr_we;
  wire  [6:0]  mem_addr = sw_buf_wr ? buf_idx : fd_we ? fd_wr.addr : cnt_reg;
  wire  [15:0] mem_data = sw_buf_wr ? writedata[15:0]
                          : fill_we ? fill_w
                          : fd_we   ? fd_w
                          : hdr_we  ? hdr_w
                          : 16'h0000;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    end_next       = end_reg;
    cmp_next       = cmp_reg;
    pend_next      = pend_reg;
    req_valid_next = fd_req_valid;
    req_next       = fd_req;
    unique case (state_reg)
      PSIE_IDLE: begin
        if (go) begin
          cmp_next  = `PSIE_CMP_OK;
          cnt_next  = 7'd0;
          // Anything other than the arming write or a matching read drops the selection
          pend_next = 1'b0;
          if (is_stat && (c_one || c_dev == `PSIE_DEV_ALL)) begin
            end_next   = c_one ? `PSIE_STAT_ONE : `PSIE_STAT_ALL;
            state_next = PSIE_FILL;
          end else if (is_isdu && c_one && len_isdu) begin
            if (!c_link) begin
              cmp_next = `PSIE_CMP_NOT_LINK;
            end else if (!c_rd && ctl_arm) begin
              pend_next = 1'b1;
            end else if (!c_rd && ctl_wr) begin
              req_next       = '{PSIE_OP_WRITE, c_port, buf_mem[0], buf_mem[1][7:0], len_reg};
              req_valid_next = 1'b1;
              state_next     = PSIE_FD_REQ;
            end else if (c_rd && pend_hit) begin
              pend_next      = 1'b1;
              req_next       = '{PSIE_OP_READ, c_port, pend_index_reg, pend_sub_reg, len_reg};
              req_valid_next = 1'b1;
              state_next     = PSIE_FD_REQ;
            end else begin
              cmp_next = `PSIE_CMP_BAD_PARAM;
            end
          end else if (is_evt && c_one && len_evt) begin
            req_next       = '{PSIE_OP_EVENT, c_port, 16'h0000, 8'h00, len_reg};
            req_valid_next = 1'b1;
            state_next     = PSIE_FD_REQ;
          end else begin
            cmp_next = `PSIE_CMP_BAD_PARAM;
          end
        end
      end
      PSIE_FILL: begin
        cnt_next = cnt_reg + 7'd1;
        if (cnt_next == end_reg) begin
          state_next = PSIE_IDLE;
        end
      end
      PSIE_FD_REQ: begin
        if (fd_req_ready) begin
          req_valid_next = 1'b0;
          state_next     = PSIE_FD_WAIT;
        end
      end
      PSIE_FD_WAIT: begin
        if (fd_rsp.done) begin
          cnt_next = (fd_rsp.len < fd_req.len) ? fd_rsp.len : fd_req.len;
          end_next = fd_req.len;
          if (fd_req.op == PSIE_OP_EVENT) begin
            state_next = (cnt_next == end_next) ? PSIE_IDLE : PSIE_ZERO;
          end else if (fd_req.op == PSIE_OP_READ) begin
            // A busy answer keeps the selection so the read may be retried
            pend_next  = fd_rsp.busy;
            cnt_next   = 7'd0;
            state_next = PSIE_HDR;
          end else begin
            state_next = PSIE_IDLE;
          end
        end
      end
      PSIE_ZERO: begin
        cnt_next = cnt_reg + 7'd1;
        if (cnt_next == end_reg) begin
          state_next = PSIE_IDLE;
        end
      end
      PSIE_HDR: begin
        cnt_next = cnt_reg + 7'd1;
        if (cnt_reg == 7'd1) begin
          state_next = PSIE_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= PSIE_IDLE;
      cnt_reg      <= 7'd0;
      end_reg      <= 7'd0;
      cmp_reg      <= `PSIE_CMP_OK;
      pend_reg     <= 1'b0;
      fd_req_valid <= 1'b0;
      fd_req       <= '0;
    end else if (ce) begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      end_reg      <= end_next;
      cmp_reg      <= cmp_next;
      pend_reg     <= pend_next;
      fd_req_valid <= req_valid_next;
      fd_req       <= req_next;
    end
  end

  // ----------------------------------------------------------------
  // Pending read selection and busy flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_port_reg  <= 3'd0;
      pend_index_reg <= 16'h0000;
      pend_sub_reg   <= 8'h00;
      busy_rsp_reg   <= 1'b0;
    end else if (ce) begin
      if (idle && go && is_isdu && !c_rd && ctl_arm) begin
        pend_port_reg  <= c_port;
        pend_index_reg <= buf_mem[0];
        pend_sub_reg   <= buf_mem[1][7:0];
      end
      if (state_reg == PSIE_FD_WAIT && fd_rsp.done) begin
        busy_rsp_reg <= fd_rsp.busy;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= 32'h0000_0000;
      len_reg <= 7'd0;
    end else if (ce) begin
      // Writes during a running instruction would corrupt its decode, so they are dropped
      if (wr_cmd && idle) begin
        cmd_reg <= {1'b0, writedata[30:0]};
      end
      if (wr_len && idle) begin
        len_reg <= writedata[6:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer memory, no reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce && mem_we) begin
      buf_mem[mem_addr] <= mem_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fd_rd_data <= 16'h0000;
    end else if (ce) begin
      fd_rd_data <= (fd_rd_addr < 7'(BUF_WORDS)) ? buf_mem[fd_rd_addr] : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Read data, one wait cycle on every read
  // ----------------------------------------------------------------
  wire  [31:0] rd_word = buf_ok ? {16'h0000, buf_mem[buf_idx]}
                         : sel_buf ? 32'h0000_0000
                         : address == `PSIE_ADDR_CMD  ? cmd_reg
                         : address == `PSIE_ADDR_LEN  ? {25'h0, len_reg}
                         : address == `PSIE_ADDR_STAT ? {cmp_reg, 14'h0, pend_reg, !idle}
                         : 32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_done_reg <= 1'b0;
      readdata    <= 32'h0000_0000;
    end else if (ce) begin
      rd_done_reg <= read && !rd_done_reg;
      if (read && !rd_done_reg) begin
        readdata <= rd_word;
      end
    end
  end

endmodule : psie_cmd
